/* File: bench/tb.sv */
// Testbench: self-checking bench for the PWM8 and cascaded timer16 block
`timescale 1ns/1ps

`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb;

  // ************************************************************
  // Signals and bookkeeping
  // ************************************************************
  logic        clk;             // 25 MHz clock
  logic        rstn;            // Synchronous reset, active low
  logic [7:0]  avs_address;     // Register byte address
  logic        avs_read;        // Read request
  logic        avs_write;       // Write request
  logic [31:0] avs_writedata;   // Write data
  logic [31:0] avs_readdata;    // Read data
  logic        avs_waitrequest; // Slave stall
  logic        low_freq_clock = 1'b0; // Slow source clock
  logic        pwm_output_pin;  // Inverted flip-flop level
  logic        irq;             // Level interrupt
  int          fails;           // Mismatch count
  int          n_tests;         // Comparison count
  int          cyc = 0;         // Free-running cycle count
  int          lf_div = 0;      // Slow clock divider
  logic [31:0] seed;            // Xorshift state
  logic [31:0] rd;              // Last read data
  logic [7:0]  offs [6];        // Offsets checked after reset
  int          act_duty;        // Model: duty in effect
  int          stg_duty;        // Model: staged duty
  int          f;               // Clocks per source tick
  int          mt;              // Timer16 match value
  int          t1;              // First interrupt cycle
  int          t2;              // Second interrupt cycle
  logic        ff;              // Flip-flop initial level
  logic        p;               // Pin level at stop
  logic [2:0]  sel;             // Source clock select
  logic [31:0] slw;             // Slow gear bit of the control word

  tpw_top #(.CNT_W(8)) dut (
    .clk             (clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .low_freq_clock  (low_freq_clock),
    .pwm_output_pin  (pwm_output_pin),  // Port latch taken as one
    .irq             (irq)
  );

  // ************************************************************
  // Clocks
  // ************************************************************
  // Main clock, 40 ns period
  always #20 clk = ~clk;

  // Slow clock at clk/16, well under the clk/2 limit
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    lf_div <= (lf_div == 7) ? 0 : lf_div + 1;
    if (lf_div == 7) begin
      low_freq_clock <= ~low_freq_clock;
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Xorshift step for repeatable random values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  // Control word from its fields
  function automatic logic [31:0] ctl(input logic fi, input logic [1:0] md,
                                      input logic run, input logic [2:0] sl);
    ctl = 32'h0000_0000;
    ctl[tpw_pkg::CTL_FFINIT] = fi;
    ctl[tpw_pkg::CTL_MODE_LSB +: 2] = md;
    ctl[tpw_pkg::CTL_RUN] = run;
    ctl[tpw_pkg::CTL_SEL_LSB +: tpw_pkg::CTL_SEL_W] = sl;
  endfunction : ctl

  // One bus access; held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk);
    // No own limit: only the watchdog ends a stalled access
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // Gap cycle keeps requests one cycle apart
    @(posedge clk);
  endtask : acc

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    @(posedge clk);
    while (irq !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, irq, 1'b1);
    end
  endtask : wait_irq

  // Count low pin samples over a whole number of periods
  task automatic meas(input int n, input int lowexp);
    int lows;
    lows = 0;
    repeat (n) begin
      @(posedge clk);
      if (pwm_output_pin === 1'b0) begin
        lows++;
      end
    end
    `CHK(32'(lows), 32'(lowexp))
  endtask : meas

  // Verdict and end of run
  task close_out;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Watchdog, about twice the expected run
  initial begin
    #2_000_000;
    fails++;
    close_out();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    fails = 0;
    n_tests = 0;
    seed = 32'h0000_001F;
    slw = 32'h0000_0001 << tpw_pkg::CTL_SLOW;
    offs = '{tpw_pkg::OFF_CTRL, tpw_pkg::OFF_DUTY, tpw_pkg::OFF_ISTAT,
             tpw_pkg::OFF_IMASK, tpw_pkg::OFF_STATUS, 8'h20};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset state, then an unmapped write that must vanish
    `CHK(pwm_output_pin, 1'b1)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, offs[i], 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
    end
    acc(1'b1, 8'h20, 32'hFFFF_FFFF);
    acc(1'b0, 8'h20, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // PWM runs: both initial levels, undivided and halved source
    for (int m = 0; m < 4; m++) begin
      ff = m[0];
      f = m[1] ? 2 : 1;
      sel = m[1] ? tpw_pkg::SEL_DIV1 : tpw_pkg::SEL_HF;
      seed = xs(seed);
      act_duty = 1 + int'(seed % 254);
      acc(1'b1, tpw_pkg::OFF_DUTY, 32'(act_duty));
      acc(1'b0, tpw_pkg::OFF_DUTY, 32'h0000_0000);
      `CHK(rd, 32'(act_duty))
      acc(1'b1, tpw_pkg::OFF_CTRL, ctl(ff, 2'b01, 1'b1, sel));
      meas(512 * f, ff ? 2 * (act_duty + 1) * f : 2 * (255 - act_duty) * f);
      // Stop keeps the init bit unchanged; pin must freeze
      acc(1'b1, tpw_pkg::OFF_CTRL, ctl(ff, 2'b01, 1'b0, sel));
      p = pwm_output_pin;
      repeat (300) @(posedge clk);
      `CHK(pwm_output_pin, p)
      acc(1'b0, tpw_pkg::OFF_STATUS, 32'h0000_0000);
      `CHK(rd, 32'({1'b0, ~p}))
      acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b0, sel));
      `CHK(pwm_output_pin, 1'b1)
      acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b1, 2'b01, 1'b0, sel));
      `CHK(pwm_output_pin, 1'b0)
    end
    // Staged duty: written after the interrupt, in effect at the next one
    seed = xs(seed);
    stg_duty = (act_duty + 1 + int'(seed % 200)) % 254 + 1;
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    acc(1'b1, tpw_pkg::OFF_IMASK, 32'h0000_0001);
    `CHK(irq, 1'b0)
    acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b1, tpw_pkg::SEL_HF));
    wait_irq(600);
    acc(1'b1, tpw_pkg::OFF_DUTY, 32'(stg_duty));
    acc(1'b0, tpw_pkg::OFF_DUTY, 32'h0000_0000);
    `CHK(rd, 32'(act_duty))
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    @(posedge clk);
    `CHK(irq, 1'b0)
    wait_irq(600);
    act_duty = stg_duty;
    acc(1'b0, tpw_pkg::OFF_DUTY, 32'h0000_0000);
    `CHK(rd, 32'(act_duty))
    meas(512, 2 * (255 - act_duty));
    acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b0, tpw_pkg::SEL_HF));
    acc(1'b1, tpw_pkg::OFF_IMASK, 32'h0000_0000);
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    // Slow gear: fast choices must leave the counter at zero
    for (int s = 1; s < 7; s++) begin
      sel = 3'(s);
      if (sel != tpw_pkg::SEL_LF) begin
        acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b1, sel) | slw);
        repeat (40) @(posedge clk);
        acc(1'b0, tpw_pkg::OFF_COUNT, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
      end
    end
    // Slow gear on the low-frequency clock: one tick every 16 clocks
    acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b1, tpw_pkg::SEL_LF) | slw);
    meas(512 * 16, 2 * (255 - act_duty) * 16);
    acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b01, 1'b0, tpw_pkg::SEL_LF));
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    // Timer16 at clk/8, match written low byte first, init bit kept 0
    seed = xs(seed);
    mt = 256 + int'(seed % 64);
    acc(1'b1, tpw_pkg::OFF_MLOW, 32'(mt % 256));
    acc(1'b1, tpw_pkg::OFF_MHIGH, 32'(mt / 256));
    acc(1'b0, tpw_pkg::OFF_MLOW, 32'h0000_0000);
    `CHK(rd, 32'(mt % 256))
    acc(1'b1, tpw_pkg::OFF_CTRL, ctl(1'b0, 2'b10, 1'b1, tpw_pkg::SEL_DIV3));
    repeat ((mt + 1) * 8 + 40) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(pwm_output_pin, 1'b1)
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    acc(1'b1, tpw_pkg::OFF_IMASK, 32'h0000_0002);
    wait_irq(3000);
    t1 = cyc;
    acc(1'b0, tpw_pkg::OFF_ISTAT, 32'h0000_0000);
    wait_irq(3000);
    t2 = cyc;
    `CHK(32'(t2 - t1), 32'((mt + 1) * 8))
    acc(1'b1, tpw_pkg::OFF_CTRL, 32'h0000_0000);
    close_out();
  end

endmodule : tb

/* File: rtl/tpw_pkg.sv */
// Package: register map, field positions and encodings of the PWM8/timer16 block
package tpw_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // timer_control_register
  localparam logic [7:0] OFF_DUTY   = 8'h04;  // duty_compare_register
  localparam logic [7:0] OFF_MLOW   = 8'h08;  // match_low_byte
  localparam logic [7:0] OFF_MHIGH  = 8'h0C;  // match_high_byte
  localparam logic [7:0] OFF_COUNT  = 8'h10;  // Live counter value
  localparam logic [7:0] OFF_ISTAT  = 8'h14;  // Sticky events, read clears
  localparam logic [7:0] OFF_IMASK  = 8'h18;  // Interrupt mask
  localparam logic [7:0] OFF_STATUS = 8'h1C;  // Flip-flop level and run state

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTL_SEL_LSB  = 0;  // Source clock select, 3 bits
  localparam int CTL_SEL_W    = 3;
  localparam int CTL_RUN      = 3;  // Run / second_counter_start_bit
  localparam int CTL_MODE_LSB = 4;  // Operating mode, 2 bits
  localparam int CTL_TAPSEL   = 6;  // divider_tap_select
  localparam int CTL_FFINIT   = 7;  // Flip-flop initial level
  localparam int CTL_SLOW     = 8;  // Slow clock-gear operation
  localparam int CTL_W        = 9;
  localparam logic [8:0] CTL_RESET = 9'h000;

  // ****************************************************************
  // Interrupt status bits and status register bits
  // ****************************************************************
  localparam int IRQ_PWM   = 0;  // PWM8 overflow
  localparam int IRQ_T16   = 1;  // Timer16 match
  localparam int IRQ_W     = 2;
  localparam int STS_FF    = 0;
  localparam int STS_RUN   = 1;

  // ****************************************************************
  // Source clock select codes
  // ****************************************************************
  localparam logic [2:0] SEL_DIV11 = 3'h0;  // hf/2^11, or lf/2^3 with tap select
  localparam logic [2:0] SEL_DIV7  = 3'h1;
  localparam logic [2:0] SEL_DIV5  = 3'h2;
  localparam logic [2:0] SEL_DIV3  = 3'h3;
  localparam logic [2:0] SEL_LF    = 3'h4;  // Undivided low-frequency clock
  localparam logic [2:0] SEL_DIV1  = 3'h5;  // hf/2
  localparam logic [2:0] SEL_HF    = 3'h6;  // Undivided high-frequency clock

  // Prescaler taps and low-frequency divide
  localparam int PRE_W  = 11;
  localparam int TAP11  = 11;
  localparam int TAP7   = 7;
  localparam int TAP5   = 5;
  localparam int TAP3   = 3;
  localparam int TAP1   = 1;
  localparam int LFDV_W = 3;

  // Operating modes
  typedef enum logic [1:0] {
    TPW_OFF   = 2'b00,
    TPW_PWM8  = 2'b01,
    TPW_TMR16 = 2'b10
  } tpw_mode_t;

endpackage : tpw_pkg

/* File: rtl/tpw_top.sv */
// Top: 8-bit PWM and 16-bit cascaded timer with an Avalon-MM register slave
//
// Functional notes
// - PWM counts up; duty match toggles flip-flop
// - Overflow toggles flip-flop, clears counter, interrupts
// - Flip-flop initial level programmable; reset clears it
// - PWM pin is inverse of flip-flop
// - Duty staged while running, loaded at interrupt
// - Duty read returns value in effect
// - Stopped pin holds; later init write sets
// - Control bit 3 is run; clear stops
// - Control bit 7 init; clear drives pin high
// - PWM source clock choices; slow limits them
// - Timer16 match interrupts, clears, keeps counting
// - Match register unbuffered, takes effect at once
// - Timer16 source clock choices; slow limits them
`timescale 1ns/1ps

module tpw_top #(
  parameter int CNT_W = 8  // Width of one counter stage
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              low_freq_clock,
  output logic                   pwm_output_pin,
  output logic                   irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [tpw_pkg::CTL_W-1:0]    ctrl_r;        // Control register
  logic [CNT_W-1:0]             duty_stage_r;  // Staging half of duty register
  logic [CNT_W-1:0]             duty_act_r;    // Compare value in effect
  logic [2*CNT_W-1:0]           match_r;       // Timer16 match pair
  logic [2*CNT_W-1:0]           cnt_r;         // Cascaded up-counter
  logic                         ff_r;          // output_flipflop
  logic                         ff_nxt;
  logic [tpw_pkg::IRQ_W-1:0]    istat_r;       // Sticky events
  logic [tpw_pkg::IRQ_W-1:0]    istat_nxt;
  logic [tpw_pkg::IRQ_W-1:0]    imask_r;       // Interrupt mask
  logic [tpw_pkg::PRE_W-1:0]    pre_r;         // Free prescaler on clk
  logic                         lf_now_r;      // Sampled low-frequency clock
  logic                         lf_prev_r;
  logic [tpw_pkg::LFDV_W-1:0]   lfdv_r;        // Low-frequency divide by 8
  logic                         wait_r;        // Waitrequest flop
  logic [31:0]                  rdata_r;
  logic                         pin_r;
  logic                         irq_r;
  logic                         acc;           // Request accepted this edge
  logic                         wr_ctrl;
  logic                         wr_duty;
  logic                         rd_istat;
  logic                         lf_rise;
  logic                         lf_div8;
  logic                         tick;          // Selected source clock pulse
  logic                         running;
  logic                         pwm_ovf;       // PWM overflow step
  logic                         pwm_hit;       // PWM duty match step
  logic                         t16_hit;       // Timer16 match step
  tpw_pkg::tpw_mode_t           mode;

  // Prescaler tap: true once every 2^k clocks
  function automatic logic tap_hit(input logic [tpw_pkg::PRE_W-1:0] p, input int k);
    logic [tpw_pkg::PRE_W-1:0] m;
    m = tpw_pkg::PRE_W'((32'h0000_0001 << k) - 32'h0000_0001);
    return (p & m) == m;
  endfunction : tap_hit

  // Field extraction used by bus and counter logic
  assign mode    = tpw_pkg::tpw_mode_t'(ctrl_r[tpw_pkg::CTL_MODE_LSB +: 2]);
  assign running = ctrl_r[tpw_pkg::CTL_RUN];
  assign acc     = (avs_read | avs_write) & ~wait_r;
  assign wr_ctrl = acc & avs_write & (avs_address == tpw_pkg::OFF_CTRL);
  assign wr_duty = acc & avs_write & (avs_address == tpw_pkg::OFF_DUTY);
  assign rd_istat = acc & avs_read & (avs_address == tpw_pkg::OFF_ISTAT);

  // ****************************************************************
  // Source clock generation
  // ****************************************************************

  // Free-running prescaler; the high-frequency clock is clk itself
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Low-frequency clock is sampled, so it must be well below clk / 2
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lf_now_r  <= 1'b0;
      lf_prev_r <= 1'b0;
      lfdv_r    <= '0;
    end else begin
      lf_now_r  <= low_freq_clock;
      lf_prev_r <= lf_now_r;
      if (lf_rise) begin
        lfdv_r <= lfdv_r + 1'b1;
      end
    end
  end
  assign lf_rise = lf_now_r & ~lf_prev_r;
  assign lf_div8 = lf_rise & (&lfdv_r);

  // Tick multiplexer; slow gear leaves only low-frequency choices
  always_comb begin
    tick = 1'b0;
    case (ctrl_r[tpw_pkg::CTL_SEL_LSB +: tpw_pkg::CTL_SEL_W])
      tpw_pkg::SEL_DIV11: begin
        tick = (ctrl_r[tpw_pkg::CTL_TAPSEL] | ctrl_r[tpw_pkg::CTL_SLOW]) ? lf_div8
             : tap_hit(pre_r, tpw_pkg::TAP11);
      end
      tpw_pkg::SEL_DIV7:  tick = ~ctrl_r[tpw_pkg::CTL_SLOW] & tap_hit(pre_r, tpw_pkg::TAP7);
      tpw_pkg::SEL_DIV5:  tick = ~ctrl_r[tpw_pkg::CTL_SLOW] & tap_hit(pre_r, tpw_pkg::TAP5);
      tpw_pkg::SEL_DIV3:  tick = ~ctrl_r[tpw_pkg::CTL_SLOW] & tap_hit(pre_r, tpw_pkg::TAP3);
      tpw_pkg::SEL_LF:    tick = (mode == tpw_pkg::TPW_PWM8) & lf_rise;
      tpw_pkg::SEL_DIV1: begin
        tick = (mode == tpw_pkg::TPW_PWM8) & ~ctrl_r[tpw_pkg::CTL_SLOW]
             & tap_hit(pre_r, tpw_pkg::TAP1);
      end
      tpw_pkg::SEL_HF:    tick = (mode == tpw_pkg::TPW_PWM8) & ~ctrl_r[tpw_pkg::CTL_SLOW];
      default:            tick = 1'b0;  // Unused code gives no clock
    endcase
  end

  // ****************************************************************
  // Counter events
  // ****************************************************************
  assign pwm_ovf = running & tick & (mode == tpw_pkg::TPW_PWM8)
                 & (&cnt_r[CNT_W-1:0]);
  assign pwm_hit = running & tick & (mode == tpw_pkg::TPW_PWM8)
                 & (cnt_r[CNT_W-1:0] == duty_act_r);
  assign t16_hit = running & tick & (mode == tpw_pkg::TPW_TMR16)
                 & (cnt_r == match_r);

  // Counter: cleared while stopped, wraps on overflow or match
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (!running || mode == tpw_pkg::TPW_OFF) begin
      cnt_r <= '0;
    end else if (pwm_ovf || t16_hit) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= (mode == tpw_pkg::TPW_PWM8) ? {{CNT_W{1'b0}}, cnt_r[CNT_W-1:0] + 1'b1}
             : cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // Output flip-flop and pin
  // ****************************************************************

  // Both toggles may land together when duty is all ones
  always_comb begin
    ff_nxt = ff_r ^ pwm_hit ^ pwm_ovf;
    if (wr_ctrl && !running && !avs_writedata[tpw_pkg::CTL_RUN]) begin
      ff_nxt = avs_writedata[tpw_pkg::CTL_FFINIT];
    end else if (wr_ctrl && !running) begin
      ff_nxt = avs_writedata[tpw_pkg::CTL_FFINIT];
    end
  end

  // Writes that stop the timer leave the level as it was
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ff_r  <= 1'b0;
      pin_r <= 1'b1;
    end else begin
      ff_r  <= ff_nxt;
      pin_r <= ~ff_nxt;
    end
  end

  // ****************************************************************
  // Registers written by software
  // ****************************************************************

  // Control register; clearing run stops at the accepting edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= tpw_pkg::CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= avs_writedata[tpw_pkg::CTL_W-1:0];
    end
  end

  // Duty: staging always, active loads at interrupt or at once when stopped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      duty_stage_r <= '0;
      duty_act_r   <= '0;
    end else begin
      if (wr_duty) begin
        duty_stage_r <= avs_writedata[CNT_W-1:0];
      end
      if (wr_duty && !running) begin
        duty_act_r <= avs_writedata[CNT_W-1:0];
      end else if (pwm_ovf) begin
        duty_act_r <= duty_stage_r;
      end
    end
  end

  // Match pair has no buffer: new bytes compare on the next tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      match_r <= '0;
    end else if (acc && avs_write) begin
      if (avs_address == tpw_pkg::OFF_MLOW) begin
        match_r[CNT_W-1:0] <= avs_writedata[CNT_W-1:0];
      end
      if (avs_address == tpw_pkg::OFF_MHIGH) begin
        match_r[2*CNT_W-1:CNT_W] <= avs_writedata[CNT_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Set wins over the read that clears
  always_comb begin
    istat_nxt = rd_istat ? '0 : istat_r;
    if (pwm_ovf) begin
      istat_nxt[tpw_pkg::IRQ_PWM] = 1'b1;
    end
    if (t16_hit) begin
      istat_nxt[tpw_pkg::IRQ_T16] = 1'b1;
    end
  end

  // Status, mask and the level interrupt
  always_ff @(posedge clk) begin
    if (!rstn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      if (acc && avs_write && avs_address == tpw_pkg::OFF_IMASK) begin
        imask_r <= avs_writedata[tpw_pkg::IRQ_W-1:0];
      end
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************

  // One wait cycle: data is latched while waitrequest is still high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
      if (avs_read && wait_r) begin
        case (avs_address)
          tpw_pkg::OFF_CTRL:   rdata_r <= 32'(ctrl_r);
          tpw_pkg::OFF_DUTY:   rdata_r <= 32'(duty_act_r);
          tpw_pkg::OFF_MLOW:   rdata_r <= 32'(match_r[CNT_W-1:0]);
          tpw_pkg::OFF_MHIGH:  rdata_r <= 32'(match_r[2*CNT_W-1:CNT_W]);
          tpw_pkg::OFF_COUNT:  rdata_r <= 32'(cnt_r);
          tpw_pkg::OFF_ISTAT:  rdata_r <= 32'(istat_r);
          tpw_pkg::OFF_IMASK:  rdata_r <= 32'(imask_r);
          tpw_pkg::OFF_STATUS: rdata_r <= 32'({running, ff_r});
          default:             rdata_r <= '0;  // Unmapped reads zero
        endcase
      end
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pwm_output_pin  = pin_r;
  assign irq             = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence ctl_write_s(bit run_v);
    wr_ctrl && avs_writedata[tpw_pkg::CTL_RUN] == run_v;
  endsequence
  sequence pwm_step_s;
    running && tick && mode == tpw_pkg::TPW_PWM8;
  endsequence

  pin_inverse_a: assert property (@(posedge clk) disable iff (!rstn)
    pwm_output_pin == ~ff_r) else $error("pin not inverse of flip-flop");
  reset_clear_a: assert property (@(posedge clk)
    !rstn |=> !ff_r && pwm_output_pin) else $error("reset did not clear flip-flop");
  duty_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
    pwm_step_s and (cnt_r[CNT_W-1:0] == duty_act_r) && !(&cnt_r[CNT_W-1:0]) && !wr_ctrl
    |=> ff_r != $past(ff_r) && cnt_r != '0) else $error("duty match did not toggle");
  overflow_a: assert property (@(posedge clk) disable iff (!rstn)
    pwm_step_s and (&cnt_r[CNT_W-1:0]) |=> cnt_r == '0 && istat_r[tpw_pkg::IRQ_PWM])
    else $error("overflow did not clear and flag");
  period_a: assert property (@(posedge clk) disable iff (!rstn)
    pwm_step_s and !(&cnt_r[CNT_W-1:0]) |=> cnt_r[CNT_W-1:0] == $past(cnt_r[CNT_W-1:0]) + 1'b1)
    else $error("pwm counter skipped");
  duty_load_a: assert property (@(posedge clk) disable iff (!rstn)
    pwm_ovf && !wr_duty |=> duty_act_r == $past(duty_stage_r)) else $error("duty not loaded");
  duty_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_duty && running && !pwm_ovf |=> duty_act_r == $past(duty_act_r))
    else $error("pending duty took effect early");
  stop_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !running && !wr_ctrl |=> $stable(ff_r)) else $error("stopped pin changed");
  run_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    ctl_write_s(1'b0) |=> !running ##1 cnt_r == '0) else $error("run clear did not stop");
  init_high_a: assert property (@(posedge clk) disable iff (!rstn)
    ctl_write_s(1'b0) and !running && !avs_writedata[tpw_pkg::CTL_FFINIT]
    |=> pwm_output_pin [*2]) else $error("init clear did not drive pin high");
  t16_match_a: assert property (@(posedge clk) disable iff (!rstn)
    t16_hit |=> cnt_r == '0 && istat_r[tpw_pkg::IRQ_T16]) else $error("timer16 match lost");
  match_now_a: assert property (@(posedge clk) disable iff (!rstn)
    acc && avs_write && avs_address == tpw_pkg::OFF_MLOW
    |=> match_r[CNT_W-1:0] == $past(avs_writedata[CNT_W-1:0])) else $error("match not direct");
  slow_clock_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_r[tpw_pkg::CTL_SLOW]
    && ctrl_r[tpw_pkg::CTL_SEL_LSB +: tpw_pkg::CTL_SEL_W] != tpw_pkg::SEL_DIV11
    && ctrl_r[tpw_pkg::CTL_SEL_LSB +: tpw_pkg::CTL_SEL_W] != tpw_pkg::SEL_LF
    |-> !tick) else $error("fast clock in slow gear");

endmodule : tpw_top
